// ### hw/pfc_config.sv
/*
 Function 1 configuration header register bank with command enables
 and shared device control. Assumes an upstream bridge presents each
 configuration or memory access as a one-cycle request on sys_clk.
*/
// Notes on behaviour
// - system error output driven only with command bit 8 set
// - parity errors reported only with command bit 6 set
// - initiator transactions started only while command bit 2 set
// - memory accesses claimed only while command bit 1 set
// - offset 08 reads fixed class code and revision, read only
// - header type field reads 80, writes ignored
// - eight-bit bus hold limit; terminate once expired and grant gone
// - window base bits 31:12 writable, low bits read 008
// - board identifier and board vendor fields, writable, reset zero
// - board vendor writes accepted only with device control bit 0
// - capability pointer reads fixed 44
// - maximum latency field reads fixed FF
// - minimum grant field reads fixed 04
// - interrupt pin field reads fixed 01
// - interrupt routing byte stored, no side effect
// - device control bit 2 selects bridge compatibility mode a
// - device control bit 1 selects bridge compatibility mode b
// - device control bits shared by both functions; bits 7:3 zero
// - configuration cycle needs select high, type 00, function 001
// - read-only writes discarded; unimplemented reads return zero
// - command all zero disconnects everything but configuration
// - writable bits clear at reset
`timescale 1ns/1ps
module pfc_config #(
    parameter logic [7:0] REVISION = 8'h00 // arbitrary value
) (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic reset, // synchronous, active high
    input pfc_pkg::pfc_req_s cfg_req, // configuration access
    input wire logic config_select_input, // device select level
    output logic cfg_ack, // one-cycle answer strobe
    output logic [31:0] cfg_rdata, // read data, registered
    input wire logic [31:0] mem_addr, // memory access address
    input wire logic mem_valid, // memory access strobe
    output logic mem_claim, // claim the memory access
    input wire logic serr_req, // internal system error event
    output logic serr_drive, // drive system error pin
    input wire logic perr_req, // internal parity error event
    output logic perr_drive, // report parity error
    input wire logic master_req, // bus logic wants to start
    output logic master_start, // start allowed
    input wire logic master_active, // own transaction under way
    input wire logic grant, // bus grant held
    output logic master_terminate, // end transaction now
    output logic lat_expired, // hold limit reached
    input pfc_pkg::pfc_devctl_s devctl_peer_wdata, // write from function 0
    input wire logic devctl_peer_we, // function 0 writes control
    output pfc_pkg::pfc_devctl_s devctl_shared, // shared control bits
    output logic bridge_compat_mode_a, // compatibility mode a
    output logic bridge_compat_mode_b, // compatibility mode b
    output logic [7:0] irq_route // routing byte for driver
);
    import pfc_pkg::*;

    pfc_state_s st_r;
    pfc_state_s st_nxt;
    logic sel_meta_r;
    logic sel_sync_r;
    logic hit;
    logic [7:0] ofs;
    logic [31:0] rd_word;
    logic cmd_zero;

    // ==========================================================
    // select pin synchroniser
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sel_meta_r <= 1'b0;
            sel_sync_r <= 1'b0;
        end else begin
            sel_meta_r <= config_select_input;
            sel_sync_r <= sel_meta_r;
        end
    end

    // ==========================================================
    // decode
    // ==========================================================
    assign ofs = {cfg_req.addr[7:2], 2'b00};
    assign hit = cfg_req.valid & sel_sync_r
        & (cfg_req.addr[1:0] == PFC_CFG_TYPE)
        & (cfg_req.addr[10:8] == PFC_FUNC_NUM);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (ofs)
            PFC_OFS_CMD: begin
                rd_word[PFC_CMD_SERR] = st_r.cmd.serr_en;
                rd_word[PFC_CMD_PERR] = st_r.cmd.perr_en;
                rd_word[PFC_CMD_MASTER] = st_r.cmd.master_en;
                rd_word[PFC_CMD_MEM] = st_r.cmd.mem_en;
            end
            PFC_OFS_CLASS: rd_word = {PFC_CLASS_CODE, REVISION};
            PFC_OFS_HDR: rd_word = {8'h00, PFC_LAYOUT_TYPE,
                st_r.bus_hold_limit, 8'h00};
            PFC_OFS_BAR0: rd_word = {st_r.window_base, PFC_BAR_LOW};
            PFC_OFS_SUBSYS: rd_word = {st_r.board_id, st_r.board_vendor};
            PFC_OFS_CAP: rd_word = {24'h000000, PFC_CAP_PTR};
            PFC_OFS_INTR: rd_word = {PFC_MAX_LAT, PFC_MIN_GNT,
                PFC_INT_PIN, st_r.irq_route};
            PFC_OFS_DEVCTL: rd_word = {29'h0, st_r.devctl};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // register update
    // ==========================================================
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = hit;
        st_nxt.rdata = (hit & ~cfg_req.write) ? rd_word : 32'h0000_0000;
        // peer function writes the shared copy
        if (devctl_peer_we) begin
            st_nxt.devctl = devctl_peer_wdata;
        end
        if (hit & cfg_req.write) begin
            case (ofs)
                PFC_OFS_CMD: begin
                    if (cfg_req.be[1]) begin
                        st_nxt.cmd.serr_en = cfg_req.wdata[PFC_CMD_SERR];
                    end
                    if (cfg_req.be[0]) begin
                        st_nxt.cmd.perr_en = cfg_req.wdata[PFC_CMD_PERR];
                        st_nxt.cmd.master_en =
                            cfg_req.wdata[PFC_CMD_MASTER];
                        st_nxt.cmd.mem_en = cfg_req.wdata[PFC_CMD_MEM];
                    end
                end
                PFC_OFS_HDR: begin
                    if (cfg_req.be[1]) begin
                        st_nxt.bus_hold_limit = cfg_req.wdata[15:8];
                    end
                end
                PFC_OFS_BAR0: begin
                    if (cfg_req.be[1]) begin
                        st_nxt.window_base[3:0] = cfg_req.wdata[15:12];
                    end
                    if (cfg_req.be[2]) begin
                        st_nxt.window_base[11:4] = cfg_req.wdata[23:16];
                    end
                    if (cfg_req.be[3]) begin
                        st_nxt.window_base[19:12] = cfg_req.wdata[31:24];
                    end
                end
                PFC_OFS_SUBSYS: begin
                    if (st_r.devctl.vendor_we) begin
                        if (cfg_req.be[0]) begin
                            st_nxt.board_vendor[7:0] = cfg_req.wdata[7:0];
                        end
                        if (cfg_req.be[1]) begin
                            st_nxt.board_vendor[15:8] = cfg_req.wdata[15:8];
                        end
                    end
                    if (cfg_req.be[2]) begin
                        st_nxt.board_id[7:0] = cfg_req.wdata[23:16];
                    end
                    if (cfg_req.be[3]) begin
                        st_nxt.board_id[15:8] = cfg_req.wdata[31:24];
                    end
                end
                PFC_OFS_INTR: begin
                    if (cfg_req.be[0]) begin
                        st_nxt.irq_route = cfg_req.wdata[7:0];
                    end
                end
                PFC_OFS_DEVCTL: begin
                    if (cfg_req.be[0]) begin
                        st_nxt.devctl = cfg_req.wdata[2:0];
                    end
                end
                default: begin
                    st_nxt.ack = hit;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.bus_hold_limit <= PFC_LAT_RESET;
            st_r.board_id <= PFC_SUBSYS_RESET;
            st_r.board_vendor <= PFC_SUBSYS_RESET;
            st_r.devctl <= PFC_DC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // enables toward the rest of the chip
    // ==========================================================
    assign cmd_zero = (st_r.cmd == '0);
    assign serr_drive = serr_req & st_r.cmd.serr_en;
    assign perr_drive = perr_req & st_r.cmd.perr_en;
    assign master_start = master_req & st_r.cmd.master_en;
    // claim inside 4 kB window only when enabled
    assign mem_claim = mem_valid & st_r.cmd.mem_en & ~cmd_zero
        & (mem_addr[31:12] == st_r.window_base);

    pfc_latency u_lat (
        .sys_clk(sys_clk),
        .reset(reset),
        .limit(st_r.bus_hold_limit),
        .master_active(master_active),
        .grant(grant),
        .expired(lat_expired),
        .terminate(master_terminate)
    );

    assign cfg_ack = st_r.ack;
    assign cfg_rdata = st_r.rdata;
    assign devctl_shared = st_r.devctl;
    assign bridge_compat_mode_a = st_r.devctl.compat_a;
    assign bridge_compat_mode_b = st_r.devctl.compat_b;
    assign irq_route = st_r.irq_route;

    // ==========================================================
    // checks
    // ==========================================================
    serr_gate_a: assert property (@(posedge sys_clk)
        disable iff (reset) serr_drive |-> st_r.cmd.serr_en)
        else $error("serr ungated");
    perr_gate_a: assert property (@(posedge sys_clk)
        disable iff (reset) perr_drive |-> st_r.cmd.perr_en)
        else $error("perr ungated");
    master_gate_a: assert property (@(posedge sys_clk)
        disable iff (reset) master_start |-> st_r.cmd.master_en)
        else $error("master");
    mem_gate_a: assert property (@(posedge sys_clk)
        disable iff (reset) mem_claim |-> st_r.cmd.mem_en)
        else $error("mem claim");
    class_read_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_CLASS
        |=> cfg_rdata[31:8] == 24'h048000) else $error("class");
    bar_low_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_BAR0
        |=> cfg_rdata[11:0] == 12'h008) else $error("bar low");
    vendor_lock_a: assert property (@(posedge sys_clk)
        disable iff (reset) !st_r.devctl.vendor_we && !devctl_peer_we
        |=> $stable(st_r.board_vendor)) else $error("vendor");
    select_need_a: assert property (@(posedge sys_clk)
        disable iff (reset) !sel_sync_r |=> !cfg_ack)
        else $error("ack unselected");
    intr_fixed_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_INTR
        |=> cfg_rdata[31:8] == 24'hFF0401) else $error("intr");

    // ==========================================================
    // decode, read-back, disconnect and reset checks
    // ==========================================================
    layout_read_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_HDR
        |=> cfg_rdata[23:16] == 8'h80) else $error("layout");
    cap_read_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_CAP
        |=> cfg_rdata == 32'h0000_0044) else $error("cap pointer");
    ctl_upper_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_DEVCTL
        |=> cfg_rdata[31:3] == 29'h0) else $error("control upper");
    cmd_unused_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit && !cfg_req.write && ofs == PFC_OFS_CMD
        |=> (cfg_rdata & 32'hFFFF_FEB9) == 32'h0) else $error("command");
    ack_timing_a: assert property (@(posedge sys_clk)
        disable iff (reset) hit |=> cfg_ack) else $error("no ack");
    ack_only_a: assert property (@(posedge sys_clk)
        disable iff (reset) !hit |=> !cfg_ack) else $error("stray ack");
    disconnect_a: assert property (@(posedge sys_clk)
        disable iff (reset) cmd_zero |-> !mem_claim && !master_start
        && !serr_drive && !perr_drive) else $error("not disconnected");
    reset_clear_a: assert property (@(posedge sys_clk)
        disable iff (reset) $fell(reset) |-> st_r.cmd == '0
        && st_r.devctl == '0 && st_r.irq_route == 8'h00)
        else $error("reset");

endmodule : pfc_config

// ### common/pfc_pkg.sv
/*
 Constants, field positions and carrier types for the function 1
 configuration header. Assumes a host-side bridge decodes
 configuration cycles into word accesses with byte enables.
*/
package pfc_pkg;

    // ==========================================================
    // register offsets (byte addresses, dword aligned)
    // ==========================================================
    localparam logic [7:0] PFC_OFS_ID = 8'h00;
    localparam logic [7:0] PFC_OFS_CMD = 8'h04;
    localparam logic [7:0] PFC_OFS_CLASS = 8'h08;
    localparam logic [7:0] PFC_OFS_HDR = 8'h0C;
    localparam logic [7:0] PFC_OFS_BAR0 = 8'h10;
    localparam logic [7:0] PFC_OFS_SUBSYS = 8'h2C;
    localparam logic [7:0] PFC_OFS_CAP = 8'h34;
    localparam logic [7:0] PFC_OFS_INTR = 8'h3C;
    localparam logic [7:0] PFC_OFS_DEVCTL = 8'h40;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int PFC_CMD_SERR = 8;
    localparam int PFC_CMD_PERR = 6;
    localparam int PFC_CMD_MASTER = 2;
    localparam int PFC_CMD_MEM = 1;
    localparam int PFC_DC_COMPAT_A = 2;
    localparam int PFC_DC_COMPAT_B = 1;
    localparam int PFC_DC_VENDOR_WE = 0;
    localparam logic [2:0] PFC_FUNC_NUM = 3'h1;
    localparam logic [1:0] PFC_CFG_TYPE = 2'h0;

    // ==========================================================
    // fixed read values and reset values
    // ==========================================================
    localparam logic [23:0] PFC_CLASS_CODE = 24'h048000;
    localparam logic [7:0] PFC_LAYOUT_TYPE = 8'h80;
    localparam logic [11:0] PFC_BAR_LOW = 12'h008;
    localparam logic [7:0] PFC_CAP_PTR = 8'h44;
    localparam logic [7:0] PFC_MAX_LAT = 8'hFF;
    localparam logic [7:0] PFC_MIN_GNT = 8'h04;
    localparam logic [7:0] PFC_INT_PIN = 8'h01;
    localparam logic [7:0] PFC_LAT_RESET = 8'h00;
    localparam logic [15:0] PFC_SUBSYS_RESET = 16'h0000;
    localparam logic [2:0] PFC_DC_RESET = 3'h0;

    // ==========================================================
    // carriers
    // ==========================================================
    typedef struct packed {
        logic valid;       // one-cycle access strobe
        logic write;       // 1 write, 0 read
        logic [10:0] addr; // function number, dword address, type
        logic [3:0] be;    // byte enables, active high
        logic [31:0] wdata;
    } pfc_req_s;

    typedef struct packed {
        logic serr_en;
        logic perr_en;
        logic master_en;
        logic mem_en;
    } pfc_cmd_s;

    typedef struct packed {
        logic compat_a;
        logic compat_b;
        logic vendor_we;
    } pfc_devctl_s;

    typedef struct packed {
        pfc_cmd_s cmd;
        logic [7:0] bus_hold_limit;
        logic [19:0] window_base;
        logic [15:0] board_id;
        logic [15:0] board_vendor;
        logic [7:0] irq_route;
        pfc_devctl_s devctl;
        logic ack;
        logic [31:0] rdata;
    } pfc_state_s;

    typedef struct packed {
        logic [7:0] count;
        logic expired;
        logic active;
    } pfc_lat_s;

endpackage : pfc_pkg

// ### hw/pfc_latency.sv
/*
 Bus hold limit counter for the initiator side.
 Assumes master_active is a level from bus logic on sys_clk.
*/
`timescale 1ns/1ps
module pfc_latency (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic [7:0] limit, // bus hold limit in clocks
    input wire logic master_active, // own transaction under way
    input wire logic grant, // bus grant still held
    output logic expired, // hold limit reached
    output logic terminate // finish transaction now
);
    import pfc_pkg::*;

    pfc_lat_s st_r;
    pfc_lat_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.active = master_active;
        if (!master_active) begin
            st_nxt.count = 8'h00;
            st_nxt.expired = 1'b0;
        end else if (!st_r.active) begin
            st_nxt.count = 8'h01;
            st_nxt.expired = (limit <= 8'h01);
        end else if (!st_r.expired) begin
            st_nxt.count = st_r.count + 8'h01;
            st_nxt.expired = (st_r.count + 8'h01 >= limit);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired = st_r.expired;
    assign terminate = st_r.expired & master_active & ~grant;

    hold_grant_a: assert property (@(posedge sys_clk)
        disable iff (reset) grant |-> !terminate)
        else $error("terminate while granted");

endmodule : pfc_latency

// ### sim/pfc_host_model.sv
/*
 Host bridge model issuing configuration cycles to function 1.
 Assumes the bench calls its tasks from one process, off sys_clk edges.
*/
`timescale 1ns/1ps
module pfc_host_model
    import pfc_pkg::*;
(
    input wire logic sys_clk, // 100 MHz clock
    output pfc_req_s cfg_req, // configuration access
    output logic config_select_input, // device select level
    input wire logic cfg_ack, // answer strobe
    input wire logic [31:0] cfg_rdata // read data
);
    initial begin
        cfg_req = '0;
        config_select_input = 1'b0;
    end

    // ==========================================================
    // single access
    // ==========================================================
    // released fields are inverted so a stale value never matches
    task automatic access(input logic wr, input logic [7:0] ofs,
        input logic [3:0] be, input logic [31:0] wd, input logic [2:0] fn,
        input logic [1:0] ty, output logic [31:0] rd, output logic hit);
        int i;
        @(posedge sys_clk);
        #1;
        cfg_req.valid = 1'b1;
        cfg_req.write = wr;
        cfg_req.addr = {fn, ofs[7:2], ty};
        cfg_req.be = be;
        cfg_req.wdata = wd;
        @(posedge sys_clk);
        #1;
        cfg_req.valid = 1'b0;
        cfg_req.addr = ~cfg_req.addr;
        cfg_req.be = ~be;
        cfg_req.wdata = ~wd;
        hit = 1'b0;
        rd = '0;
        for (i = 0; i < 3; i++) begin
            if (cfg_ack === 1'b1) begin
                rd = cfg_rdata;
                hit = 1'b1;
                break;
            end
            @(posedge sys_clk);
            #1;
        end
    endtask : access

    // select changes only between accesses; the device syncs it late
    task automatic select(input logic lvl);
        @(posedge sys_clk);
        #1;
        config_select_input = lvl;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : select

    // ==========================================================
    // boot firmware
    // ==========================================================
    // base and routing written at boot
    task automatic boot_firmware(input logic [31:0] base,
        input logic [7:0] route);
        logic [31:0] d;
        logic h;
        access(1'b1, PFC_OFS_BAR0, 4'hF, base, PFC_FUNC_NUM, 2'h0, d, h);
        access(1'b1, PFC_OFS_INTR, 4'h1, {24'h0, route}, PFC_FUNC_NUM,
            2'h0, d, h);
    endtask : boot_firmware
endmodule : pfc_host_model

// ### sim/pfc_config_tb.sv
/*
 Self-checking bench for the function 1 configuration header.
 Assumes the host model drives configuration cycles; the bench drives
 the remaining inputs 1 ns after the rising edge.
*/
`timescale 1ns/1ps
module pfc_config_tb;
    import pfc_pkg::*;
    localparam logic [7:0] REV = 8'h3C; // arbitrary value
    typedef struct packed {
        logic wr;
        logic [7:0] ofs;
        logic [3:0] be;
        logic [31:0] wd;
        logic [31:0] exp;
    } pfc_tb_row_s;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    pfc_req_s cfg_req;
    logic sel, cfg_ack, mem_claim, serr_drive, perr_drive, master_start;
    logic [31:0] cfg_rdata, d;
    logic [31:0] mem_addr = '0;
    logic mem_valid = 1'b0, serr_req = 1'b0, perr_req = 1'b0;
    logic master_req = 1'b0, master_active = 1'b0, grant = 1'b0;
    logic peer_we = 1'b0, hit;
    logic master_terminate, lat_expired, mode_a, mode_b;
    pfc_devctl_s peer_wd = '0;
    pfc_devctl_s devctl_shared;
    logic [7:0] irq_route;
    int n_errors = 0;
    int checks_done = 0;
    int k;
    pfc_tb_row_s rows [0:17] = '{
        '{1'b0, 8'h08, 4'hF, 32'h0, {24'h048000, REV}},
        '{1'b1, 8'h08, 4'hF, 32'hFFFFFFFF, {24'h048000, REV}},
        '{1'b0, 8'h0C, 4'hF, 32'h0, 32'h00800000},
        '{1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF, 32'h0080FF00},
        '{1'b0, 8'h10, 4'hF, 32'h0, 32'h00000008},
        '{1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'hFFFFF008},
        '{1'b1, 8'h10, 4'h2, 32'h0, 32'hFFFF0008},
        '{1'b0, 8'h34, 4'hF, 32'h0, 32'h00000044},
        '{1'b1, 8'h3C, 4'hF, 32'hFFFFFF5A, 32'hFF04015A},
        '{1'b0, 8'h2C, 4'hF, 32'h0, 32'h0},
        '{1'b1, 8'h2C, 4'hF, 32'h12345678, 32'h12340000},
        '{1'b0, 8'h04, 4'hF, 32'h0, 32'h0},
        '{1'b1, 8'h04, 4'hF, 32'hFFFFFFFF, 32'h00000146},
        '{1'b0, 8'h40, 4'hF, 32'h0, 32'h0},
        '{1'b1, 8'h40, 4'hF, 32'hFFFFFFFF, 32'h00000007},
        '{1'b1, 8'h2C, 4'hF, 32'hABCD1234, 32'hABCD1234},
        '{1'b1, 8'h20, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'b0, 8'h00, 4'hF, 32'h0, 32'h0}};

    always #5 sys_clk = ~sys_clk;

    pfc_host_model u_pfc_host_model (.sys_clk(sys_clk), .cfg_req(cfg_req),
        .config_select_input(sel), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata));
    pfc_config #(.REVISION(REV)) u_pfc_config (.sys_clk(sys_clk),
        .reset(reset), .cfg_req(cfg_req), .config_select_input(sel),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .mem_addr(mem_addr),
        .mem_valid(mem_valid), .mem_claim(mem_claim),
        .serr_req(serr_req), .serr_drive(serr_drive),
        .perr_req(perr_req), .perr_drive(perr_drive),
        .master_req(master_req), .master_start(master_start),
        .master_active(master_active), .grant(grant),
        .master_terminate(master_terminate), .lat_expired(lat_expired),
        .devctl_peer_wdata(peer_wd), .devctl_peer_we(peer_we),
        .devctl_shared(devctl_shared), .bridge_compat_mode_a(mode_a),
        .bridge_compat_mode_b(mode_b), .irq_route(irq_route));

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s %b", $time, what, got);
        end
    endtask : chk1

    task automatic cfg(input logic wr, input logic [7:0] ofs,
        input logic [3:0] be, input logic [31:0] wd);
        u_pfc_host_model.access(wr, ofs, be, wd, PFC_FUNC_NUM, 2'h0, d, hit);
        chk1(hit, 1'b1, "ack");
    endtask : cfg

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // hang guard, far beyond the roughly 120 cycles the run needs
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        $display("wrong value at %0t: watchdog ran out", $time);
        give_verdict();
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (4) step();
        reset = 1'b0;
        u_pfc_host_model.select(1'b1);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                cfg(1'b1, rows[i].ofs, rows[i].be, rows[i].wd);
            end
            cfg(1'b0, rows[i].ofs, 4'hF, 32'h0);
            chk32(d, rows[i].exp, "row");
        end
        $display("table rows done");
        serr_req = 1'b1;
        perr_req = 1'b1;
        master_req = 1'b1;
        mem_valid = 1'b1;
        mem_addr = 32'hFFFF0ABC;
        step();
        chk1(serr_drive, 1'b1, "serr");
        chk1(perr_drive, 1'b1, "perr");
        chk1(master_start, 1'b1, "start");
        chk1(mem_claim, 1'b1, "claim");
        mem_addr = 32'hFFFE0ABC;
        step();
        chk1(mem_claim, 1'b0, "claim off window");
        mem_addr = 32'hFFFF0ABC;
        cfg(1'b1, PFC_OFS_CMD, 4'hF, 32'h0);
        chk1(serr_drive | perr_drive | master_start | mem_claim, 1'b0,
            "disconnected");
        cfg(1'b0, PFC_OFS_CLASS, 4'hF, 32'h0);
        chk32(d, {PFC_CLASS_CODE, REV}, "class while off");
        $display("enables done");
        u_pfc_host_model.access(1'b0, 8'h08, 4'hF, 32'h0, 3'h0, 2'h0, d,
            hit);
        chk1(hit, 1'b0, "other function");
        u_pfc_host_model.access(1'b0, 8'h08, 4'hF, 32'h0, PFC_FUNC_NUM,
            2'h1, d, hit);
        chk1(hit, 1'b0, "type 01");
        u_pfc_host_model.select(1'b0);
        u_pfc_host_model.access(1'b0, 8'h08, 4'hF, 32'h0, PFC_FUNC_NUM,
            2'h0, d, hit);
        chk1(hit, 1'b0, "select low");
        u_pfc_host_model.select(1'b1);
        $display("decode done");
        chk32({29'h0, devctl_shared}, 32'h7, "own devctl");
        chk1(mode_b, 1'b1, "mode b on");
        peer_wd = 3'b100;
        peer_we = 1'b1;
        step();
        peer_we = 1'b0;
        step();
        chk32({29'h0, devctl_shared}, 32'h4, "peer devctl");
        chk1(mode_a, 1'b1, "mode a");
        chk1(mode_b, 1'b0, "mode b");
        cfg(1'b0, PFC_OFS_DEVCTL, 4'hF, 32'h0);
        chk32(d, 32'h4, "devctl read");
        $display("shared control done");
        cfg(1'b1, PFC_OFS_HDR, 4'h2, 32'h00000300);
        master_active = 1'b1;
        grant = 1'b1;
        step();
        chk1(lat_expired, 1'b0, "early expiry");
        for (k = 0; k < 6 && lat_expired !== 1'b1; k++) begin
            step();
        end
        chk1(lat_expired, 1'b1, "expiry");
        chk32(k, 32'd2, "expiry cycles");
        chk1(master_terminate, 1'b0, "grant held");
        grant = 1'b0;
        step();
        chk1(master_terminate, 1'b1, "grant gone");
        master_active = 1'b0;
        $display("latency done");
        u_pfc_host_model.boot_firmware(32'h12345000, 8'hA5);
        step();
        chk32({24'h0, irq_route}, 32'hA5, "route");
        reset = 1'b1;
        repeat (4) step();
        reset = 1'b0;
        repeat (3) step();
        chk32({24'h0, irq_route}, 32'h0, "route reset");
        cfg(1'b0, PFC_OFS_BAR0, 4'hF, 32'h0);
        chk32(d, 32'h00000008, "base reset");
        cfg(1'b0, PFC_OFS_CMD, 4'hF, 32'h0);
        chk32(d, 32'h0, "command reset");
        chk32({29'h0, devctl_shared}, 32'h0, "devctl reset");
        $display("reset done");
        give_verdict();
    end
endmodule : pfc_config_tb
